/* logic/pmc_pkg.sv */
package pmc_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] ADR_GLOBAL = 8'h00;
   localparam logic [7:0] ADR_BCAST  = 8'h04;
   localparam logic [7:0] ADR_PSEL   = 8'h08;
   localparam logic [7:0] ADR_CTRL   = 8'h0C;
   localparam logic [7:0] ADR_MDIX   = 8'h10;
   localparam logic [7:0] ADR_AUX    = 8'h14;
   localparam logic [7:0] ADR_XOVER  = 8'h18;
   localparam logic [7:0] ADR_DSHIFT = 8'h1C;
   localparam logic [7:0] ADR_EEE    = 8'h20;
   localparam logic [7:0] ADR_MACAN  = 8'h24;
   localparam logic [7:0] ADR_RESULT = 8'h28;
   localparam logic [7:0] ADR_NPAGE  = 8'h2C;

   // Field positions
   localparam int GLB_MODE_HI = 15;
   localparam int GLB_MODE_LO = 14;
   localparam int BC_EN       = 0;
   localparam int CT_AN_EN    = 12;
   localparam int CT_SPD_MSB  = 6;
   localparam int CT_SPD_LSB  = 13;
   localparam int CT_DUPLEX   = 8;
   localparam int MX_FRC_DIS  = 7;
   localparam int MX_AUTO_DIS = 5;
   localparam int MX_POL_DIS  = 4;
   localparam int XO_HI       = 3;
   localparam int XO_LO       = 2;
   localparam int DS_EN       = 4;
   localparam int DS_CNT_HI   = 3;
   localparam int DS_CNT_LO   = 2;
   localparam int DS_STAT     = 1;
   localparam int EE_TE       = 15;
   localparam int EE_TEST     = 5;
   localparam int MA_AN       = 7;

   // Reset values
   localparam logic [15:0] GLOBAL_RST = 16'h0000;
   localparam logic [15:0] CTRL_RST   = 16'h1140;
   localparam logic [15:0] MDIX_RST   = 16'h0080;
   localparam logic [15:0] ZERO_RST   = 16'h0000;

   // Encodings
   localparam logic [1:0] MODE_QSG_A   = 2'h0;
   localparam logic [1:0] MODE_QSG_B   = 2'h2;
   localparam logic [1:0] XO_STRAIGHT  = 2'h2;
   localparam logic [1:0] XO_CROSSED   = 2'h3;
   localparam logic [1:0] SPD_10       = 2'h0;
   localparam logic [1:0] SPD_100      = 2'h1;
   localparam logic [1:0] SPD_1000     = 2'h2;
   localparam logic [4:0] BASE_00      = 5'h00;
   localparam logic [4:0] BASE_01      = 5'h0C;
   localparam logic [4:0] BASE_10      = 5'h04;
   localparam logic [4:0] BASE_11      = 5'h14;
   localparam logic [2:0] DS_MIN_TRIES = 3'h2;
   localparam int         PORTS_PER_LANE = 4;

   typedef enum logic {PMC_DS_FULL, PMC_DS_SHIFTED} pmc_ds_t;

   // Line-side observations per port
   typedef struct packed {
      logic       an_able;
      logic       gig_able;
      logic       fast_able;
      logic       full_able;
      logic       np_able;
      logic [1:0] pd_speed;
      logic       crossed;
      logic       cd_swap;
      logic [3:0] pol_inv;
      logic       master_pref;
      logic       gig_fail;
      logic       link_ok;
      logic       lpi_req;
   } pmc_line_t;

   // Resolved configuration per port
   typedef struct packed {
      logic        link_en;
      logic [1:0]  speed;
      logic        full_dup;
      logic        master;
      logic        crossed_wiring;
      logic        cd_swap;
      logic [3:0]  pol_fix;
      logic [1:0]  lane;
      logic        mac_an_en;
      logic        low_power_idle;
      logic        te_mode;
      logic        test_1000;
      logic        adv_gig;
      logic        np_valid;
      logic [15:0] np_word;
   } pmc_port_t;

endpackage

/* logic/pmc_phy_cfg.sv */
`timescale 1ns/1ps
// Overview of operation
// - Global SerDes register written once; per-port writes go per port or by broadcast.
// - MAC side runs QSGMII when global mode field is 00 or 10.
// - Each port enables MAC-side autonegotiation with its own bit.
// - Two address straps pick internal PHY address range: 0, 12, 4 or 20 base.
// - Each lane carries speed and duplex of four ports, any speed, both duplexes.
// - Three lanes; lane n serves QSGMII group n.
// - Autonegotiation picks best common speed, duplex and gigabit master/slave role.
// - Optional next page lets the MAC pass attributes to the partner.
// - Partner without autonegotiation gets speed by parallel detection.
// - Clearing autonegotiation enable forces speed and duplex from control bits.
// - Test bit plus forced gigabit engages forced gigabit test mode.
// - Auto crossover and polarity correction on at reset, controllable, status readable.
// - With forced-speed disable bit clear, auto crossover also runs when forced.
// - Auto crossover handles straight, crossed, and both with C/D swapped.
// - Manual crossover field: 10 straight, 11 crossed, 00 automatic.
// - Downshift after failed gigabit tries; recovers with new partner, no reset.
// - Downshift field configures and reports the downshift feature.
// - Low power idle used only at 100 and 1000 Mbit/s.
// - Per-port bit selects reduced-amplitude 10 Mbit/s mode.
// - Reversed polarity corrected on every pair.
// - Page-suffixed registers are per page; bit 15 is the MSB.
module pmc_phy_cfg
   import pmc_pkg::*;
#(
   parameter int NPORT = 12,
   parameter int NLANE = 3
)
(
   // Clock and reset
   input  logic                   CLK_SYS,
   input  logic                   RESET_N,
   // Wishbone slave
   input  logic [7:0]             ADR_I,
   input  logic [31:0]            DAT_I,
   input  logic [3:0]             SEL_I,
   input  logic                   WE_I,
   input  logic                   CYC_I,
   input  logic                   STB_I,
   output logic [31:0]            DAT_O,
   output logic                   ACK_O,
   // Address straps
   input  logic                   ADDRESS_STRAP_HIGH,
   input  logic                   ADDRESS_STRAP_LOW,
   // Line side
   input  pmc_line_t [NPORT-1:0]  LINE_I,
   // Resolved per-port configuration
   output pmc_port_t [NPORT-1:0]  PORT_CFG,
   output logic                   QSGMII_EN,
   output logic [NLANE-1:0]       LANE_EN
);

   localparam int PW = $clog2(NPORT);

   logic            ack_q;
   logic [31:0]     dat_q;
   logic [15:0]     glob_q;
   logic            bcast_q;
   logic [4:0]      psel_q;
   logic [4:0]      base_q;
   logic [15:0]     ctrl_q  [NPORT];
   logic [15:0]     mdix_q  [NPORT];
   logic [15:0]     xo_q    [NPORT];
   logic [15:0]     ds_q    [NPORT];
   logic [15:0]     ee_q    [NPORT];
   logic [15:0]     ma_q    [NPORT];
   logic [15:0]     np_q    [NPORT];
   pmc_ds_t         ds_st_q [NPORT];
   logic [2:0]      cnt_q   [NPORT];
   logic            link_q  [NPORT];
   pmc_port_t       port_q  [NPORT];
   pmc_port_t       port_d  [NPORT];
   logic            wb_req;
   logic            wb_wr;
   logic [4:0]      poff;
   logic            hit;
   logic [PW-1:0]   ridx;
   logic [15:0]     r16;
   logic [1:0]      gmode;

   function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
      wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   assign wb_req = CYC_I & STB_I & ~ack_q;
   assign wb_wr  = wb_req & WE_I;
   assign ACK_O  = ack_q;
   assign DAT_O  = dat_q;

   // Own address decode within strapped range
   assign poff = psel_q - base_q;
   assign hit  = (psel_q >= base_q) && (poff < 5'(NPORT));
   assign ridx = poff[PW-1:0];

   // Strap capture while reset is held
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         unique case ({ADDRESS_STRAP_HIGH, ADDRESS_STRAP_LOW})
            2'h0: base_q <= BASE_00;
            2'h1: base_q <= BASE_01;
            2'h2: base_q <= BASE_10;
            2'h3: base_q <= BASE_11;
         endcase
      end
   end

   // Bus handshake
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
         ack_q <= 1'b0;
      else
         ack_q <= wb_req;
   end

   // Device-wide registers
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         glob_q  <= GLOBAL_RST;
         bcast_q <= 1'b0;
         psel_q  <= 5'h00;
      end
      else if (wb_wr)
      begin
         if (ADR_I == ADR_GLOBAL)
            glob_q <= wmerge(glob_q, DAT_I, SEL_I);
         if (ADR_I == ADR_BCAST && SEL_I[0])
            bcast_q <= DAT_I[BC_EN];
         if (ADR_I == ADR_PSEL && SEL_I[0])
            psel_q <= DAT_I[4:0];
      end
   end

   // MAC-side mode
   assign gmode     = glob_q[GLB_MODE_HI:GLB_MODE_LO];
   assign QSGMII_EN = (gmode == MODE_QSG_A) || (gmode == MODE_QSG_B);
   assign LANE_EN   = {NLANE{QSGMII_EN}};

   genvar p;
   generate
      for (p = 0; p < NPORT; p++)
      begin : g_port
         logic       pw;
         logic       an_en;
         logic [1:0] fspd;
         logic       auto_x;
         logic       frc_gig_fail;
         logic [2:0] limit;
         pmc_line_t  ln;

         assign ln  = LINE_I[p];
         assign pw  = wb_wr & (bcast_q | (hit && ridx == PW'(p)));
         assign an_en  = ctrl_q[p][CT_AN_EN];
         assign fspd   = {ctrl_q[p][CT_SPD_MSB], ctrl_q[p][CT_SPD_LSB]};
         assign auto_x = ~mdix_q[p][MX_AUTO_DIS] & (an_en | ~mdix_q[p][MX_FRC_DIS]);
         assign limit  = {1'b0, ds_q[p][DS_CNT_HI:DS_CNT_LO]} + DS_MIN_TRIES;
         assign frc_gig_fail = ln.gig_fail & ds_q[p][DS_EN] & an_en & (ds_st_q[p] == PMC_DS_FULL);

         // Per-port registers
         always_ff @(posedge CLK_SYS)
         begin
            if (!RESET_N)
            begin
               ctrl_q[p] <= CTRL_RST;
               mdix_q[p] <= MDIX_RST;
               xo_q[p]   <= ZERO_RST;
               ds_q[p]   <= ZERO_RST;
               ee_q[p]   <= ZERO_RST;
               ma_q[p]   <= ZERO_RST;
               np_q[p]   <= ZERO_RST;
            end
            else if (pw)
            begin
               case (ADR_I)
                  ADR_CTRL:   ctrl_q[p] <= wmerge(ctrl_q[p], DAT_I, SEL_I);
                  ADR_MDIX:   mdix_q[p] <= wmerge(mdix_q[p], DAT_I, SEL_I);
                  ADR_XOVER:  xo_q[p]   <= wmerge(xo_q[p], DAT_I, SEL_I);
                  ADR_DSHIFT: ds_q[p]   <= wmerge(ds_q[p], DAT_I, SEL_I);
                  ADR_EEE:    ee_q[p]   <= wmerge(ee_q[p], DAT_I, SEL_I);
                  ADR_MACAN:  ma_q[p]   <= wmerge(ma_q[p], DAT_I, SEL_I);
                  ADR_NPAGE:  np_q[p]   <= wmerge(np_q[p], DAT_I, SEL_I);
                  default:    ;
               endcase
            end
         end

         // Downshift tracking
         always_ff @(posedge CLK_SYS)
         begin
            if (!RESET_N)
            begin
               ds_st_q[p] <= PMC_DS_FULL;
               cnt_q[p]   <= 3'h0;
               link_q[p]  <= 1'b0;
            end
            else
            begin
               link_q[p] <= ln.link_ok;
               if (frc_gig_fail)
               begin
                  cnt_q[p] <= cnt_q[p] + 3'h1;
                  if (cnt_q[p] + 3'h1 >= limit)
                     ds_st_q[p] <= PMC_DS_SHIFTED;
               end
               else if (link_q[p] && !ln.link_ok)
               begin
                  ds_st_q[p] <= PMC_DS_FULL;
                  cnt_q[p]   <= 3'h0;
               end
            end
         end

         // Mode resolution
         always_comb
         begin
            port_d[p]         = '0;
            port_d[p].adv_gig = (ds_st_q[p] == PMC_DS_FULL);
            port_d[p].link_en = 1'b1;
            if (an_en)
            begin
               if (ln.an_able)
               begin
                  if (port_d[p].adv_gig && ln.gig_able)
                     port_d[p].speed = SPD_1000;
                  else if (ln.fast_able)
                     port_d[p].speed = SPD_100;
                  else
                     port_d[p].speed = SPD_10;
                  port_d[p].full_dup = ln.full_able & ctrl_q[p][CT_DUPLEX];
                  port_d[p].master   = (port_d[p].speed == SPD_1000) & ~ln.master_pref;
               end
               else
               begin
                  port_d[p].speed    = ln.pd_speed;
                  port_d[p].full_dup = 1'b0;
               end
            end
            else
            begin
               port_d[p].speed     = fspd;
               port_d[p].full_dup  = ctrl_q[p][CT_DUPLEX];
               port_d[p].test_1000 = ee_q[p][EE_TEST] & (fspd == SPD_1000);
               port_d[p].link_en   = (fspd != SPD_1000) | port_d[p].test_1000;
               port_d[p].master    = port_d[p].test_1000 & ~ln.master_pref;
            end
            case (xo_q[p][XO_HI:XO_LO])
               XO_STRAIGHT: port_d[p].crossed_wiring = 1'b0;
               XO_CROSSED:  port_d[p].crossed_wiring = 1'b1;
               default:
               begin
                  port_d[p].crossed_wiring = auto_x & ln.crossed;
                  port_d[p].cd_swap        = auto_x & ln.cd_swap;
               end
            endcase
            port_d[p].pol_fix   = mdix_q[p][MX_POL_DIS] ? 4'h0 : ln.pol_inv;
            port_d[p].lane      = 2'(p / PORTS_PER_LANE);
            port_d[p].mac_an_en = ma_q[p][MA_AN];
            port_d[p].low_power_idle = ln.lpi_req & ln.link_ok
                                       & (port_d[p].speed != SPD_10);
            port_d[p].te_mode   = ee_q[p][EE_TE] & (port_d[p].speed == SPD_10);
            port_d[p].np_valid  = an_en & ln.an_able & ln.np_able & (np_q[p] != ZERO_RST);
            port_d[p].np_word   = np_q[p];
         end

         always_ff @(posedge CLK_SYS)
         begin
            if (!RESET_N)
               port_q[p] <= '0;
            else
               port_q[p] <= port_d[p];
         end

         assign PORT_CFG[p] = port_q[p];
      end
   endgenerate

   // Read mux
   always_comb
   begin
      r16 = 16'h0000;
      case (ADR_I)
         ADR_GLOBAL: r16 = glob_q;
         ADR_BCAST:  r16 = {15'h0000, bcast_q};
         ADR_PSEL:   r16 = {11'h000, psel_q};
         default:
         begin
            if (hit)
            begin
               case (ADR_I)
                  ADR_CTRL:   r16 = ctrl_q[ridx];
                  ADR_MDIX:   r16 = mdix_q[ridx];
                  ADR_XOVER:  r16 = xo_q[ridx];
                  ADR_DSHIFT: r16 = {ds_q[ridx][15:DS_STAT+1],
                                     ds_st_q[ridx] == PMC_DS_SHIFTED, ds_q[ridx][0]};
                  ADR_EEE:    r16 = ee_q[ridx];
                  ADR_MACAN:  r16 = ma_q[ridx];
                  ADR_NPAGE:  r16 = np_q[ridx];
                  ADR_AUX:    r16 = {9'h000, port_q[ridx].crossed_wiring,
                                     port_q[ridx].cd_swap, 1'b0, port_q[ridx].pol_fix};
                  ADR_RESULT: r16 = {port_q[ridx].link_en, port_q[ridx].speed,
                                     port_q[ridx].full_dup, port_q[ridx].master,
                                     port_q[ridx].lane, port_q[ridx].mac_an_en,
                                     port_q[ridx].low_power_idle, port_q[ridx].te_mode,
                                     port_q[ridx].test_1000, port_q[ridx].adv_gig,
                                     port_q[ridx].np_valid, 3'h0};
                  default:    r16 = 16'h0000;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
         dat_q <= 32'h0000_0000;
      else if (wb_req)
         dat_q <= {16'h0000, r16};
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   strap_base_a: assert property (
      disable iff (1'b0) (!RESET_N && ADDRESS_STRAP_HIGH && ADDRESS_STRAP_LOW) |=> base_q == BASE_11)
      else $error("strap base not captured");

   bcast_write_a: assert property (
      (wb_wr && bcast_q && ADR_I == ADR_EEE && SEL_I[1:0] == 2'h3)
      |=> (ee_q[0] == $past(DAT_I[15:0])) && (ee_q[NPORT-1] == $past(DAT_I[15:0])))
      else $error("broadcast did not reach all ports");

   port_miss_a: assert property (
      (wb_wr && !bcast_q && !hit && ADR_I == ADR_CTRL) |=> $stable(ctrl_q[0]))
      else $error("write outside range changed a port");

   qsgmii_mode_a: assert property (
      (glob_q[GLB_MODE_HI] == 1'b0 && glob_q[GLB_MODE_LO] == 1'b1) |-> !QSGMII_EN ##1 1'b1)
      else $error("QSGMII on for illegal mode");

   forced_speed_a: assert property (
      !ctrl_q[0][CT_AN_EN] ##1 !ctrl_q[0][CT_AN_EN]
      |-> PORT_CFG[0].speed == {$past(ctrl_q[0][CT_SPD_MSB]), $past(ctrl_q[0][CT_SPD_LSB])})
      else $error("forced speed not applied");

   xover_force_a: assert property (
      (xo_q[0][XO_HI:XO_LO] == XO_CROSSED) ##1 (xo_q[0][XO_HI:XO_LO] == XO_CROSSED)
      |-> PORT_CFG[0].crossed_wiring)
      else $error("manual crossed wiring ignored");

   pol_disable_a: assert property (
      mdix_q[0][MX_POL_DIS] [*2] |-> PORT_CFG[0].pol_fix == 4'h0)
      else $error("polarity fixed while disabled");

   lpi_speed_a: assert property (
      PORT_CFG[0].low_power_idle |-> PORT_CFG[0].speed != SPD_10)
      else $error("low power idle at 10 Mbit/s");

   downshift_a: assert property (
      (ds_st_q[0] == PMC_DS_SHIFTED) |=> !PORT_CFG[0].adv_gig)
      else $error("gigabit advertised after downshift");

   test_mode_a: assert property (
      PORT_CFG[0].speed == SPD_1000 && !$past(ctrl_q[0][CT_AN_EN]) && PORT_CFG[0].link_en
      |-> PORT_CFG[0].test_1000)
      else $error("forced gigabit without test bit");

   bus_ack_a: assert property (
      wb_req |=> ACK_O ##1 !ACK_O)
      else $error("bus answer not one cycle");

endmodule

/* test/pmc_line_model.sv */
`timescale 1ns/1ps
module pmc_line_model
   import pmc_pkg::*;
#(
   parameter int NPORT = 12
)
(
   // Clock
   input  logic                  clk_sys,
   // Bench control
   input  pmc_line_t             profile,
   input  logic                  fail_req,
   // Line observations
   output pmc_line_t [NPORT-1:0] line_o
);

   pmc_line_t obs;

   // Cable partner profile with the commanded gigabit failure pulse
   always_comb
   begin
      obs          = profile;
      obs.gig_fail = fail_req;
   end

   // Same cable partner on every port, wiring and pair polarity as commanded
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < NPORT; i++)
         line_o[i] <= obs;
   end

endmodule

/* test/pmc_phy_cfg_bench.sv */
`timescale 1ns/1ps
module pmc_phy_cfg_bench;
   import pmc_pkg::*;

   localparam int NP = 12;

   logic               clk_sys = 1'b0;
   logic               reset_n = 1'b0;
   logic [7:0]         adr = 8'h00;
   logic [31:0]        dat = 32'h00000000;
   logic [3:0]         sel = 4'h0;
   logic               we = 1'b0;
   logic               cyc = 1'b0;
   logic               stb = 1'b0;
   logic               strap_hi = 1'b0;
   logic               strap_lo = 1'b0;
   logic               fail_req = 1'b0;
   pmc_line_t          prof;
   pmc_line_t [NP-1:0] line;
   pmc_port_t [NP-1:0] cfg;
   logic [31:0]        dat_o;
   logic               ack;
   logic               qsg_en;
   logic [2:0]         lane_en;
   logic               qe;
   logic [15:0]        exp_q[$];
   int                 mismatches = 0;
   int                 num_checks = 0;
   int                 seed = 32'h06541D36;
   logic [15:0]        rv;
   logic [4:0]         base;

   always #10 clk_sys = ~clk_sys;

   pmc_phy_cfg pmc_phy_cfg_i (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel),
      .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o), .ACK_O(ack),
      .ADDRESS_STRAP_HIGH(strap_hi), .ADDRESS_STRAP_LOW(strap_lo), .LINE_I(line),
      .PORT_CFG(cfg), .QSGMII_EN(qsg_en), .LANE_EN(lane_en));

   pmc_line_model #(.NPORT(NP)) pmc_line_model_i (
      .clk_sys(clk_sys), .profile(prof), .fail_req(fail_req), .line_o(line));

   task automatic end_sim();
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic report(input logic bad, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (bad)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rd(input logic [31:0] got, input logic [15:0] exp);
      report(got !== {16'h0000, exp}, got, {16'h0000, exp});
   endtask

   task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
      report(got !== exp, {16'h0000, got}, {16'h0000, exp});
   endtask

   // Classic single cycle; read expectation queued for the monitor
   task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [15:0] e);
      @(posedge clk_sys);
      adr <= a;
      we  <= w;
      dat <= {16'h0000, d};
      sel <= 4'h3;
      cyc <= 1'b1;
      stb <= 1'b1;
      if (!w)
         exp_q.push_back(e);
      do
      begin
         @(posedge clk_sys);
      end
      while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic settle();
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic do_reset(input logic [1:0] s);
      @(posedge clk_sys);
      reset_n  <= 1'b0;
      strap_hi <= s[1];
      strap_lo <= s[0];
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
   endtask

   task automatic fail_try();
      @(posedge clk_sys);
      fail_req <= 1'b1;
      @(posedge clk_sys);
      fail_req <= 1'b0;
   endtask

   // Read data checker
   always @(posedge clk_sys)
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         chk_rd(dat_o, exp_q.pop_front());

   initial
   begin
      prof = '{an_able: 1'b1, gig_able: 1'b1, fast_able: 1'b1, full_able: 1'b1,
               link_ok: 1'b1, lpi_req: 1'b1, default: '0};
      do_reset(2'h0);
      wb(ADR_CTRL, 1'b0, 16'h0000, CTRL_RST);
      wb(ADR_MDIX, 1'b0, 16'h0000, MDIX_RST);
      wb(8'hFC, 1'b0, 16'h0000, 16'h0000);
      // MAC-side mode field
      for (int m = 0; m < 4; m++)
      begin
         wb(ADR_GLOBAL, 1'b1, {m[1:0], 14'h0000}, 16'h0000);
         qe = (m[1:0] == 2'h0) || (m[1:0] == 2'h2);
         chk_cfg(16'(qsg_en), 16'(qe));
         chk_cfg(16'(lane_en), 16'({3{qe}}));
      end
      wb(ADR_GLOBAL, 1'b1, 16'h0000, 16'h0000);
      // Address ranges from the straps
      for (int s = 0; s < 4; s++)
      begin
         do_reset(s[1:0]);
         base = (s == 0) ? 5'h00 : (s == 1) ? 5'h0C : (s == 2) ? 5'h04 : 5'h14;
         wb(ADR_PSEL, 1'b1, 16'(base + 5'h0C), 16'h0000);
         wb(ADR_CTRL, 1'b1, 16'h0000, 16'h0000);
         wb(ADR_CTRL, 1'b0, 16'h0000, 16'h0000);
         wb(ADR_PSEL, 1'b1, 16'(base + 5'h0B), 16'h0000);
         wb(ADR_CTRL, 1'b0, 16'h0000, CTRL_RST);
      end
      do_reset(2'h0);
      // Next page word
      rv = 16'($random(seed));
      wb(ADR_NPAGE, 1'b1, rv, 16'h0000);
      wb(ADR_NPAGE, 1'b0, 16'h0000, rv);
      chk_cfg(cfg[0].np_word, rv);
      // Pair polarity
      prof.pol_inv <= 4'($random(seed));
      settle();
      chk_cfg(16'(cfg[0].pol_fix), 16'(prof.pol_inv));
      wb(ADR_AUX, 1'b0, 16'h0000, 16'(prof.pol_inv));
      wb(ADR_MDIX, 1'b1, 16'h0090, 16'h0000);
      settle();
      chk_cfg(16'(cfg[0].pol_fix), 16'h0000);
      wb(ADR_MDIX, 1'b1, MDIX_RST, 16'h0000);
      // Four wiring arrangements
      for (int k = 0; k < 4; k++)
      begin
         prof.crossed <= k[1];
         prof.cd_swap <= k[0];
         settle();
         chk_cfg(16'({cfg[0].crossed_wiring, cfg[0].cd_swap}), 16'(k[1:0]));
      end
      wb(ADR_XOVER, 1'b1, 16'h0008, 16'h0000);
      settle();
      chk_cfg(16'(cfg[0].crossed_wiring), 16'h0000);
      wb(ADR_XOVER, 1'b1, 16'h000C, 16'h0000);
      prof.crossed <= 1'b0;
      settle();
      chk_cfg(16'(cfg[0].crossed_wiring), 16'h0001);
      wb(ADR_XOVER, 1'b1, 16'h0000, 16'h0000);
      prof.crossed <= 1'b1;
      // Forced speeds
      wb(ADR_CTRL, 1'b1, 16'h2100, 16'h0000);
      settle();
      chk_cfg(16'({cfg[0].speed, cfg[0].full_dup}), 16'({SPD_100, 1'b1}));
      chk_cfg(16'(cfg[0].crossed_wiring), 16'h0000);
      wb(ADR_MDIX, 1'b1, 16'h0000, 16'h0000);
      settle();
      chk_cfg(16'(cfg[0].crossed_wiring), 16'h0001);
      wb(ADR_CTRL, 1'b1, 16'h0140, 16'h0000);
      settle();
      chk_cfg(16'(cfg[0].link_en), 16'h0000);
      wb(ADR_EEE, 1'b1, 16'h0020, 16'h0000);
      settle();
      chk_cfg(16'({cfg[0].link_en, cfg[0].test_1000, cfg[0].speed}), 16'({2'h3, SPD_1000}));
      wb(ADR_CTRL, 1'b1, CTRL_RST, 16'h0000);
      wb(ADR_MDIX, 1'b1, MDIX_RST, 16'h0000);
      // Per-port MAC autonegotiation, then broadcast
      wb(ADR_MACAN, 1'b1, 16'h0080, 16'h0000);
      settle();
      chk_cfg(16'({cfg[0].mac_an_en, cfg[1].mac_an_en}), 16'h0002);
      wb(ADR_BCAST, 1'b1, 16'h0001, 16'h0000);
      wb(ADR_EEE, 1'b1, 16'h8000, 16'h0000);
      wb(ADR_BCAST, 1'b1, 16'h0000, 16'h0000);
      // Partner limited to 10 Mbit/s so the reduced-amplitude mode applies
      prof.gig_able  <= 1'b0;
      prof.fast_able <= 1'b0;
      settle();
      for (int i = 0; i < NP; i++)
      begin
         chk_cfg(16'({cfg[i].te_mode, cfg[i].lane}), 16'({1'b1, 2'(i / 4)}));
         chk_cfg(16'(cfg[i].low_power_idle), 16'h0000);
      end
      prof.gig_able  <= 1'b1;
      prof.fast_able <= 1'b1;
      // Downshift after two failed gigabit tries
      wb(ADR_DSHIFT, 1'b1, 16'h0010, 16'h0000);
      fail_try();
      settle();
      chk_cfg(16'(cfg[0].adv_gig), 16'h0001);
      chk_cfg(16'({cfg[0].low_power_idle, cfg[0].master}), 16'h0003);
      fail_try();
      settle();
      chk_cfg(16'(cfg[0].adv_gig), 16'h0000);
      wb(ADR_DSHIFT, 1'b0, 16'h0000, 16'h0012);
      prof.link_ok <= 1'b0;
      settle();
      chk_cfg(16'(cfg[0].adv_gig), 16'h0001);
      wb(ADR_DSHIFT, 1'b0, 16'h0000, 16'h0010);
      settle();
      end_sim();
   end

   // Watchdog
   initial
   begin
      #(20 * 20000);
      mismatches++;
      end_sim();
   end

endmodule
